// file: tces_pkg.sv
// constants and types for the translation command error syndrome capture block
package tces_pkg;

	// ********************************************************
	// register map (word offsets on the register port)
	// ********************************************************
	localparam logic [3:0] TCES_ADDR_STATUS = 4'h0;
	localparam logic [3:0] TCES_ADDR_SYNDROME = 4'h1;
	localparam logic [3:0] TCES_ADDR_EXTRA = 4'h2;
	localparam logic [3:0] TCES_ADDR_CTRL = 4'h3;
	localparam logic [3:0] TCES_ADDR_OPR = 4'h4;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int TCES_ST_UNCORR_BIT = 29;
	localparam int TCES_ST_OVERFLOW_BIT = 27;
	localparam int TCES_ST_MISCV_BIT = 26;
	localparam int TCES_ST_IMPL_BIT = 8;
	localparam int TCES_SYN_W = 24;
	localparam int TCES_CNT_LSB = 24;
	localparam int TCES_CNT_W = 8;
	localparam int TCES_CTRL_CORR_EN_BIT = 0;
	localparam int TCES_CTRL_UNCORR_EN_BIT = 1;
	localparam int TCES_CTRL_RESUME_BIT = 2;
	localparam int TCES_OPR_STALLED_BIT = 0;
	localparam int TCES_OPR_FAIL_BIT = 1;
	localparam logic [31:0] TCES_CTRL_RESET = 32'h0000_0003;
	localparam logic [23:0] TCES_SYN_RESET = 24'h00_0000;
	localparam logic [31:0] TCES_EXTRA_NONE = 32'h0000_0000;

	// ********************************************************
	// syndrome codes
	// ********************************************************
	localparam logic [23:0] SYN_MOVE_ALL_SRC_ABSENT = 24'h010e20;
	localparam logic [23:0] SYN_MOVE_ALL_DST_ABSENT = 24'h010e21;
	localparam logic [23:0] SYN_MOVE_ALL_DST_CHIP_OFF = 24'h010e22;
	localparam logic [23:0] SYN_MOVE_ALL_SRC_IRQ_OFF = 24'h010e23;
	localparam logic [23:0] SYN_MOVE_ALL_DST_IRQ_OFF = 24'h010e24;
	localparam logic [23:0] SYN_XLATE_PHYS_ID_RANGE = 24'h010326;
	localparam logic [23:0] SYN_XLATE_TGT_ABSENT = 24'h010320;
	localparam logic [23:0] SYN_XLATE_CHIP_OFF = 24'h010322;
	localparam logic [23:0] SYN_XLATE_IRQ_OFF = 24'h010323;
	localparam logic [23:0] SYN_LOCK_PHYS_ID_RANGE = 24'h010f26;
	localparam logic [23:0] SYN_LOCK_TGT_ABSENT = 24'h010f20;
	localparam logic [23:0] SYN_LOCK_IRQ_OFF = 24'h010f23;
	localparam logic [23:0] SYN_MAP_DEV_RANGE = 24'h010801;
	localparam logic [23:0] SYN_MAP_DEV_TABLE_SIZE = 24'h010802;
	localparam logic [23:0] SYN_MAP_COLL_RANGE = 24'h010903;
	localparam logic [23:0] SYN_MAP_COLL_TGT_ABSENT = 24'h010920;
	localparam logic [23:0] SYN_MAP_COLL_CHIP_OFF = 24'h010922;
	localparam logic [23:0] SYN_MAP_COLL_IRQ_OFF = 24'h010923;
	localparam logic [23:0] SYN_MAP_INT_DEV_RANGE = 24'h010b01;
	localparam logic [23:0] SYN_MAP_INT_COLL_RANGE = 24'h010b03;
	localparam logic [23:0] SYN_MAP_INT_DEV_UNMAPPED = 24'h010b04;
	localparam logic [23:0] SYN_MAP_INT_ID_SIZE = 24'h010b05;
	localparam logic [23:0] SYN_MAP_VID_DEV_RANGE = 24'h010a01;
	localparam logic [23:0] SYN_MAP_VID_COLL_RANGE = 24'h010a03;
	localparam logic [23:0] SYN_MAP_VID_DEV_UNMAPPED = 24'h010a04;
	localparam logic [23:0] SYN_MAP_VID_ID_RANGE = 24'h010a05;
	localparam logic [23:0] SYN_MAP_VID_PHYS_RANGE = 24'h010a06;
	localparam logic [23:0] SYN_MOVE_INT_DEV_RANGE = 24'h010101;
	localparam logic [23:0] SYN_MOVE_INT_COLL_RANGE = 24'h010103;
	localparam logic [23:0] SYN_MOVE_INT_DEV_UNMAPPED = 24'h010104;
	localparam logic [23:0] SYN_MOVE_INT_ID_RANGE = 24'h010105;
	localparam logic [23:0] SYN_MOVE_INT_IRQ_UNMAPPED = 24'h010107;
	localparam logic [23:0] SYN_MOVE_INT_COLL_UNMAPPED = 24'h010109;
	localparam logic [23:0] SYN_DISCARD_DEV_RANGE = 24'h010f01;
	localparam logic [23:0] SYN_DISCARD_DEV_UNMAPPED = 24'h010f04;
	localparam logic [23:0] SYN_DISCARD_ID_RANGE = 24'h010f05;
	localparam logic [23:0] SYN_DISCARD_IRQ_UNMAPPED = 24'h010f07;
	localparam logic [23:0] SYN_DISCARD_ENTRY_INVALID = 24'h010f10;

	// ********************************************************
	// carriers
	// ********************************************************
	// error event reported by the command, translation or lock logic
	typedef struct packed {
		logic [23:0] syndrome;
		logic [31:0] extra;
	} tces_evt_s;

	// per-syndrome handling decision
	typedef struct packed {
		logic impl;
		logic stall;
		logic corr_mask;
		logic ignore;
		logic drop;
		logic opr_fail;
	} tces_dec_s;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} tces_req_s;

endpackage

// file: tces_top.sv
// syndrome capture, error record registers and queue stall control
// ********************************************************
// Summary of operation
// - one software error record holding contained uncorrectable command errors
// - implementation flag reads 0 for architecture errors, 1 for implementation errors
// - full 24-bit syndrome in syndrome word, extra data in extra word
// - move-all from absent source core: 0x010e20, flag set, no stall, ignored
// - move-all to absent or offline destination: no stall, source interrupts dropped
// - move-all with irqs off: 0x010e23 ignored, 0x010e24 drops, no stall
// - translation with physical ID too wide: dropped, no stall, ID recorded
// - translation to absent or offline core: dropped, no stall, target recorded
// - translation to target with irqs off: 0x010323, no stall, target recorded
// - failing cache lock reports fail in operation register, no stall
// - map-device range error 0x010801 stalls, gated by correctable enable
// - table size beyond event-ID size 0x010802 stalls the queue
// - map-collection with bad collection 0x010903 stalls the queue
// - map-collection absent core stalls inside service, else ignored with core
// - extra data zero marks service-side detection, only that is masked
// - map-collection irqs off or chip offline reported without stall
// - map-interrupt errors stall with architecture syndromes
// - map-virtual-ID errors stall with their syndromes
// - move-interrupt errors 0x010101 to 0x010109 stall the queue
// - discard errors stall the queue with their syndromes
// - valid-bit clears ignored while overflow set and not cleared
// - while misc valid set, only the counter field of misc words is writable
// ********************************************************
`timescale 1ns/1ps

module tces_top
	import tces_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// error event from the command, translation and lock paths
	input wire logic evt_valid_i,
	input wire tces_evt_s evt_i,
	// register port
	input wire tces_req_s req_i,
	output logic [31:0] rdata_o,
	// effects toward the service
	output logic stall_o,
	output logic cmd_ignore_o,
	output logic irq_drop_o,
	output logic opr_fail_o,
	output logic fault_o
);

	// ********************************************************
	// syndrome decode
	// ********************************************************
	// map a syndrome and its extra data onto its handling
	function automatic tces_dec_s decode(input logic [23:0] syn, input logic [31:0] extra);
		tces_dec_s d;
		d = '0;
		unique case (syn)
			SYN_MOVE_ALL_SRC_ABSENT, SYN_MOVE_ALL_SRC_IRQ_OFF: begin
				d.impl = 1'b1;
				d.ignore = 1'b1;
			end
			SYN_MOVE_ALL_DST_ABSENT, SYN_MOVE_ALL_DST_CHIP_OFF,
			SYN_MOVE_ALL_DST_IRQ_OFF: begin
				d.impl = 1'b1;
				d.drop = 1'b1;
			end
			SYN_XLATE_PHYS_ID_RANGE, SYN_XLATE_TGT_ABSENT, SYN_XLATE_CHIP_OFF: begin
				d.impl = 1'b1;
				d.drop = 1'b1;
			end
			SYN_XLATE_IRQ_OFF: begin
				d.impl = 1'b1;
			end
			SYN_LOCK_PHYS_ID_RANGE, SYN_LOCK_TGT_ABSENT, SYN_LOCK_IRQ_OFF: begin
				d.impl = 1'b1;
				d.opr_fail = 1'b1;
			end
			SYN_MAP_DEV_RANGE, SYN_MAP_DEV_TABLE_SIZE, SYN_MAP_COLL_RANGE: begin
				d.stall = 1'b1;
				d.corr_mask = 1'b1;
			end
			SYN_MAP_COLL_TGT_ABSENT: begin
				d.impl = 1'b1;
				if (extra == TCES_EXTRA_NONE) begin
					d.stall = 1'b1;
					d.corr_mask = 1'b1;
				end else begin
					d.ignore = 1'b1;
				end
			end
			SYN_MAP_COLL_CHIP_OFF, SYN_MAP_COLL_IRQ_OFF: begin
				d.impl = 1'b1;
			end
			SYN_MAP_INT_DEV_RANGE, SYN_MAP_INT_COLL_RANGE, SYN_MAP_INT_DEV_UNMAPPED,
			SYN_MAP_INT_ID_SIZE: begin
				d.stall = 1'b1;
				d.corr_mask = 1'b1;
			end
			SYN_MAP_VID_DEV_RANGE, SYN_MAP_VID_COLL_RANGE, SYN_MAP_VID_DEV_UNMAPPED,
			SYN_MAP_VID_ID_RANGE, SYN_MAP_VID_PHYS_RANGE: begin
				d.stall = 1'b1;
				d.corr_mask = 1'b1;
			end
			SYN_MOVE_INT_DEV_RANGE, SYN_MOVE_INT_COLL_RANGE, SYN_MOVE_INT_DEV_UNMAPPED,
			SYN_MOVE_INT_ID_RANGE, SYN_MOVE_INT_IRQ_UNMAPPED,
			SYN_MOVE_INT_COLL_UNMAPPED: begin
				d.stall = 1'b1;
				d.corr_mask = 1'b1;
			end
			SYN_DISCARD_DEV_RANGE, SYN_DISCARD_DEV_UNMAPPED, SYN_DISCARD_ID_RANGE,
			SYN_DISCARD_IRQ_UNMAPPED, SYN_DISCARD_ENTRY_INVALID: begin
				d.stall = 1'b1;
				d.corr_mask = 1'b1;
			end
			default: begin
				d.impl = 1'b1; // unlisted codes: recorded, fault_o gated by uncorrectable enable, no stall, ignore, drop or fail
			end
		endcase
		return d;
	endfunction

	// ********************************************************
	// state
	// ********************************************************
	logic uncorr_valid_r;
	logic overflow_flag_r;
	logic misc_valid_flag_r;
	logic impl_flag_r;
	logic [23:0] syndrome_r;
	logic [7:0] counter_r;
	logic [31:0] extra_r;
	logic corr_en_r;
	logic uncorr_en_r;
	logic lock_fail_r;
	tces_dec_s dec;
	logic cap;
	logic wr_status;
	logic wr_syn;
	logic wr_extra;
	logic wr_ctrl;
	logic wr_opr;
	logic ovf_clear;
	logic valid_clear_ok;

	// decode of the incoming event and register writes
	always_comb begin
		dec = decode(evt_i.syndrome, evt_i.extra);
		cap = ce_i && evt_valid_i;
		wr_status = ce_i && req_i.wr && (req_i.addr == TCES_ADDR_STATUS);
		wr_syn = ce_i && req_i.wr && (req_i.addr == TCES_ADDR_SYNDROME);
		wr_extra = ce_i && req_i.wr && (req_i.addr == TCES_ADDR_EXTRA);
		wr_ctrl = ce_i && req_i.wr && (req_i.addr == TCES_ADDR_CTRL);
		wr_opr = ce_i && req_i.wr && (req_i.addr == TCES_ADDR_OPR);
		ovf_clear = wr_status && req_i.wdata[TCES_ST_OVERFLOW_BIT];
		valid_clear_ok = !overflow_flag_r || ovf_clear;
	end

	// ********************************************************
	// status flags, capture wins over a clear in the same cycle
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			uncorr_valid_r <= 1'b0;
			overflow_flag_r <= 1'b0;
			misc_valid_flag_r <= 1'b0;
			impl_flag_r <= 1'b0;
		end else if (cap) begin
			uncorr_valid_r <= 1'b1;
			misc_valid_flag_r <= 1'b1;
			impl_flag_r <= dec.impl;
			if (uncorr_valid_r) begin
				overflow_flag_r <= 1'b1; // earlier record overwritten
			end else if (ovf_clear) begin
				overflow_flag_r <= 1'b0;
			end
		end else if (wr_status) begin
			if (ovf_clear) begin
				overflow_flag_r <= 1'b0;
			end
			if (valid_clear_ok && req_i.wdata[TCES_ST_UNCORR_BIT]) begin
				uncorr_valid_r <= 1'b0;
			end
			if (valid_clear_ok && req_i.wdata[TCES_ST_MISCV_BIT]) begin
				misc_valid_flag_r <= 1'b0;
			end
		end
	end

	// ********************************************************
	// syndrome and extra data words
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			syndrome_r <= TCES_SYN_RESET;
			extra_r <= TCES_EXTRA_NONE;
		end else if (cap) begin
			syndrome_r <= evt_i.syndrome;
			extra_r <= evt_i.extra;
		end else begin
			if (wr_syn && !misc_valid_flag_r) begin
				syndrome_r <= req_i.wdata[TCES_SYN_W-1:0];
			end
			if (wr_extra && !misc_valid_flag_r) begin
				extra_r <= req_i.wdata;
			end
		end
	end

	// error counter, writable even while the misc words are locked
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			counter_r <= '0;
		end else if (cap) begin
			counter_r <= counter_r + 8'h01;
		end else if (wr_syn) begin
			counter_r <= req_i.wdata[TCES_CNT_LSB +: TCES_CNT_W];
		end
	end

	// ********************************************************
	// control register
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			corr_en_r <= TCES_CTRL_RESET[TCES_CTRL_CORR_EN_BIT];
			uncorr_en_r <= TCES_CTRL_RESET[TCES_CTRL_UNCORR_EN_BIT];
		end else if (wr_ctrl) begin
			corr_en_r <= req_i.wdata[TCES_CTRL_CORR_EN_BIT];
			uncorr_en_r <= req_i.wdata[TCES_CTRL_UNCORR_EN_BIT];
		end
	end

	// ********************************************************
	// queue stall, held until software resumes
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stall_o <= 1'b0;
		end else if (cap && dec.stall) begin
			stall_o <= 1'b1;
		end else if (wr_ctrl && req_i.wdata[TCES_CTRL_RESUME_BIT]) begin
			stall_o <= 1'b0;
		end
	end

	// lock failure flag in the operation register, write one to clear
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_fail_r <= 1'b0;
		end else if (cap && dec.opr_fail) begin
			lock_fail_r <= 1'b1;
		end else if (wr_opr && req_i.wdata[TCES_OPR_FAIL_BIT]) begin
			lock_fail_r <= 1'b0;
		end
	end

	// ********************************************************
	// one-cycle effect pulses
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_ignore_o <= 1'b0;
			irq_drop_o <= 1'b0;
			opr_fail_o <= 1'b0;
			fault_o <= 1'b0;
		end else if (ce_i) begin
			cmd_ignore_o <= evt_valid_i && dec.ignore;
			irq_drop_o <= evt_valid_i && dec.drop;
			opr_fail_o <= evt_valid_i && dec.opr_fail;
			fault_o <= evt_valid_i && (dec.corr_mask ? corr_en_r : uncorr_en_r);
		end
	end

	// ********************************************************
	// read data, one cycle after the read strobe
	// ********************************************************
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (ce_i) begin
			rdata_o <= '0;
			if (req_i.rd) begin
				unique case (req_i.addr)
					TCES_ADDR_STATUS: begin
						rdata_o[TCES_ST_UNCORR_BIT] <= uncorr_valid_r;
						rdata_o[TCES_ST_OVERFLOW_BIT] <= overflow_flag_r;
						rdata_o[TCES_ST_MISCV_BIT] <= misc_valid_flag_r;
						rdata_o[TCES_ST_IMPL_BIT] <= impl_flag_r;
					end
					TCES_ADDR_SYNDROME: begin
						rdata_o <= {counter_r, syndrome_r};
					end
					TCES_ADDR_EXTRA: begin
						rdata_o <= extra_r;
					end
					TCES_ADDR_CTRL: begin
						rdata_o[TCES_CTRL_CORR_EN_BIT] <= corr_en_r;
						rdata_o[TCES_CTRL_UNCORR_EN_BIT] <= uncorr_en_r;
					end
					TCES_ADDR_OPR: begin
						rdata_o[TCES_OPR_STALLED_BIT] <= stall_o;
						rdata_o[TCES_OPR_FAIL_BIT] <= lock_fail_r;
					end
					default: begin
						rdata_o <= '0; // unmapped reads as zero
					end
				endcase
			end
		end
	end

endmodule

// file: tces_top_props.sv
// assertions on the ports of the error syndrome capture block
`timescale 1ns/1ps

module tces_top_props
	import tces_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// event and register port
	input wire logic evt_valid_i,
	input wire tces_evt_s evt_i,
	input wire tces_req_s req_i,
	// outputs under watch
	input wire logic [31:0] rdata_o,
	input wire logic stall_o,
	input wire logic cmd_ignore_o,
	input wire logic irq_drop_o,
	input wire logic opr_fail_o,
	input wire logic fault_o
);
	logic corr_en_r;
	logic unc_en_r;
	logic take_w;
	logic resume_w;
	logic [23:0] syn_w;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// decoded event take and resume request
	assign take_w = ce_i && evt_valid_i;
	assign syn_w = evt_i.syndrome;
	assign resume_w = ce_i && req_i.wr && req_i.addr == TCES_ADDR_CTRL &&
		req_i.wdata[TCES_CTRL_RESUME_BIT];

	// shadow of the event enables, so fault gating can be judged from outside
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			corr_en_r <= 1'b1;
			unc_en_r <= 1'b1;
		end else if (ce_i && req_i.wr && req_i.addr == TCES_ADDR_CTRL) begin
			corr_en_r <= req_i.wdata[TCES_CTRL_CORR_EN_BIT];
			unc_en_r <= req_i.wdata[TCES_CTRL_UNCORR_EN_BIT];
		end
	end

	// ********************************************************
	// per-syndrome effects
	// ********************************************************
	chk_move_ignore: assert property (take_w && syn_w inside {24'h010e20, 24'h010e23}
		|=> cmd_ignore_o && !irq_drop_o) else $error("move-all ignore missing");
	chk_move_drop: assert property (take_w && syn_w inside {24'h010e21, 24'h010e22,
		24'h010e24} |=> irq_drop_o && !cmd_ignore_o) else $error("move-all drop missing");
	chk_xlate_drop: assert property (take_w && syn_w inside {24'h010326, 24'h010320,
		24'h010322} |=> irq_drop_o) else $error("translation drop missing");
	chk_lock_fail: assert property (take_w && syn_w inside {24'h010f26, 24'h010f20,
		24'h010f23} |=> opr_fail_o && !irq_drop_o) else $error("lock fail missing");
	chk_quiet_no_stall: assert property (
		take_w && !stall_o && (syn_w[15:8] inside {8'h0e, 8'h03} ||
		syn_w inside {24'h010f26, 24'h010f20, 24'h010f23, 24'h010922, 24'h010923}) |=> !stall_o)
		else $error("non-stalling syndrome stalled");
	chk_map_stall: assert property (take_w &&
		syn_w inside {24'h010801, 24'h010802, 24'h010903} |=> stall_o)
		else $error("map error did not stall");
	chk_cmd_stall: assert property (take_w && syn_w inside {
		24'h010b01, 24'h010b03, 24'h010b04, 24'h010b05, 24'h010a01, 24'h010a03, 24'h010a04,
		24'h010a05, 24'h010a06, 24'h010101, 24'h010103, 24'h010104, 24'h010105, 24'h010107,
		24'h010109, 24'h010f01, 24'h010f04, 24'h010f05, 24'h010f07, 24'h010f10} |=> stall_o)
		else $error("command error did not stall");
	chk_coll_stall: assert property (take_w && syn_w == 24'h010920 &&
		evt_i.extra == 32'h0 |=> stall_o) else $error("collection target error did not stall");
	chk_coll_ignore: assert property (take_w && syn_w == 24'h010920 &&
		evt_i.extra != 32'h0 && !stall_o |=> cmd_ignore_o && !stall_o)
		else $error("collection target not ignored");

	// ********************************************************
	// queue stall and fault gating
	// ********************************************************
	chk_stall_hold: assert property (stall_o && !resume_w |=> stall_o)
		else $error("stall dropped without resume");
	chk_resume_release: assert property (stall_o && resume_w && !evt_valid_i |=> !stall_o)
		else $error("resume did not release stall");
	chk_fault_corr: assert property (take_w && !req_i.wr && syn_w == 24'h010801
		|=> fault_o == $past(corr_en_r)) else $error("masked fault wrong");
	chk_fault_unc: assert property (take_w && !req_i.wr && syn_w == 24'h010e20
		|=> fault_o == $past(unc_en_r)) else $error("unmasked fault wrong");
endmodule

bind tces_top tces_top_props chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
	.evt_valid_i(evt_valid_i), .evt_i(evt_i), .req_i(req_i), .rdata_o(rdata_o),
	.stall_o(stall_o), .cmd_ignore_o(cmd_ignore_o), .irq_drop_o(irq_drop_o),
	.opr_fail_o(opr_fail_o), .fault_o(fault_o));

// file: tces_top_tb.sv
// self-checking bench for the error syndrome capture block
`timescale 1ns/1ps

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
	$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tces_top_tb
	import tces_pkg::*;
;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ce_i = 1'b1;
	logic evt_valid_i = 1'b0;
	tces_evt_s evt_i = '0;
	tces_req_s req_i = '0;
	logic [31:0] rdata_o;
	logic stall_o;
	logic cmd_ignore_o;
	logic irq_drop_o;
	logic opr_fail_o;
	logic fault_o;
	int failures = 0;
	int checks_done = 0;
	logic [7:0] cnt = 8'h00;
	// syndrome in [31:8]; flags: 5 zero extra, 4 impl, 3 stall, 2 ignore, 1 drop, 0 lock fail
	logic [31:0] tab [0:38] = '{32'h010e20_14, 32'h010e21_12, 32'h010e22_12, 32'h010e23_14,
		32'h010e24_12, 32'h010326_12, 32'h010320_12, 32'h010322_12, 32'h010323_10,
		32'h010f26_11, 32'h010f20_11, 32'h010f23_11, 32'h010801_08, 32'h010802_08,
		32'h010903_08, 32'h010920_38, 32'h010920_14, 32'h010923_10, 32'h010922_10,
		32'h010b01_08, 32'h010b03_08, 32'h010b05_08, 32'h010b04_08, 32'h010a01_08,
		32'h010a03_08, 32'h010a04_08, 32'h010a05_08, 32'h010a06_08, 32'h010101_08,
		32'h010103_08, 32'h010104_08, 32'h010105_08, 32'h010107_08, 32'h010109_08,
		32'h010f01_08, 32'h010f04_08, 32'h010f05_08, 32'h010f07_08, 32'h010f10_08};

	// clock generator
	always #5 clk_i = ~clk_i;

	tces_top dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .evt_valid_i(evt_valid_i),
		.evt_i(evt_i), .req_i(req_i), .rdata_o(rdata_o), .stall_o(stall_o),
		.cmd_ignore_o(cmd_ignore_o), .irq_drop_o(irq_drop_o), .opr_fail_o(opr_fail_o),
		.fault_o(fault_o));

	// ********************************************************
	// bus and event tasks
	// ********************************************************
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req_i.wr <= 1'b1;
		req_i.addr <= a;
		req_i.wdata <= d;
		@(posedge clk_i);
		req_i.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_i);
		req_i.rd <= 1'b1;
		req_i.addr <= a;
		@(posedge clk_i);
		req_i.rd <= 1'b0;
		#1;
		`CHK(rdata_o, e)
	endtask

	task automatic evt(input logic [23:0] s, input logic [31:0] x);
		@(posedge clk_i);
		evt_valid_i <= 1'b1;
		evt_i <= {s, x};
		@(posedge clk_i);
		evt_valid_i <= 1'b0;
		cnt = cnt + 8'h01;
		#1;
	endtask

	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_reset;
		rd_chk(TCES_ADDR_STATUS, 32'h0);
		rd_chk(TCES_ADDR_SYNDROME, 32'h0);
		rd_chk(TCES_ADDR_EXTRA, TCES_EXTRA_NONE);
		rd_chk(TCES_ADDR_CTRL, TCES_CTRL_RESET);
		rd_chk(TCES_ADDR_OPR, 32'h0);
		wr(4'hf, 32'hffff_ffff);
		rd_chk(4'hf, 32'h0);
		$display("test reset values done");
	endtask

	task automatic t_table;
		logic [31:0] e;
		logic [31:0] x;
		logic [4:0] fx;
		for (int i = 0; i < 39; i++) begin
			e = tab[i];
			x = e[5] ? 32'h0 : {8'h5a, e[31:8]};
			evt(e[31:8], x);
			fx = {stall_o, cmd_ignore_o, irq_drop_o, opr_fail_o, fault_o};
			`CHK(fx, {e[3:0], 1'b1})
			rd_chk(TCES_ADDR_STATUS, 32'h2400_0000 | {23'h0, e[4], 8'h00});
			rd_chk(TCES_ADDR_SYNDROME, {cnt, e[31:8]});
			rd_chk(TCES_ADDR_EXTRA, x);
			rd_chk(TCES_ADDR_OPR, {30'h0, e[0], e[3]});
			wr(TCES_ADDR_STATUS, 32'h2c00_0000);
			wr(TCES_ADDR_OPR, 32'h0000_0002);
			wr(TCES_ADDR_CTRL, 32'h0000_0007);
			#1;
			`CHK(stall_o, 1'b0)
		end
		$display("test syndrome table done");
	endtask

	task automatic t_overflow;
		@(posedge clk_i);
		evt_valid_i <= 1'b1;
		evt_i <= {SYN_MOVE_ALL_SRC_ABSENT, 32'h0000_0011};
		@(posedge clk_i);
		evt_i <= {SYN_XLATE_PHYS_ID_RANGE, 32'h0000_1234};
		@(posedge clk_i);
		evt_valid_i <= 1'b0;
		#1;
		`CHK(irq_drop_o, 1'b1)
		rd_chk(TCES_ADDR_STATUS, 32'h2c00_0100);
		wr(TCES_ADDR_STATUS, 32'h2400_0000);
		rd_chk(TCES_ADDR_STATUS, 32'h2c00_0100);
		wr(TCES_ADDR_SYNDROME, 32'hff12_3456);
		wr(TCES_ADDR_EXTRA, 32'h0);
		rd_chk(TCES_ADDR_SYNDROME, {8'hff, SYN_XLATE_PHYS_ID_RANGE});
		rd_chk(TCES_ADDR_EXTRA, 32'h0000_1234);
		wr(TCES_ADDR_STATUS, 32'h2c00_0000);
		wr(TCES_ADDR_SYNDROME, 32'h0100_0abc);
		rd_chk(TCES_ADDR_SYNDROME, 32'h0100_0abc);
		$display("test overflow and write guard done");
	endtask

	task automatic t_mask;
		wr(TCES_ADDR_CTRL, 32'h0);
		evt(SYN_MAP_DEV_RANGE, 32'h0);
		`CHK({stall_o, fault_o}, 2'b10)
		evt(SYN_MAP_COLL_TGT_ABSENT, 32'h0000_0007);
		`CHK({cmd_ignore_o, fault_o}, 2'b10)
		wr(TCES_ADDR_CTRL, 32'h0000_0005);
		evt(SYN_MAP_DEV_RANGE, 32'h0);
		`CHK(fault_o, 1'b1)
		evt(SYN_MOVE_ALL_SRC_ABSENT, 32'h0);
		`CHK(fault_o, 1'b0)
		wr(TCES_ADDR_CTRL, 32'h0000_0006);
		evt(SYN_MAP_COLL_TGT_ABSENT, 32'h0);
		`CHK({stall_o, fault_o}, 2'b10)
		wr(TCES_ADDR_CTRL, 32'h0000_0007);
		wr(TCES_ADDR_STATUS, 32'h2c00_0000);
		$display("test fault masking done");
	endtask

	// event offered while the clock enable is low must not be taken
	task automatic t_hold;
		@(posedge clk_i);
		ce_i <= 1'b0;
		evt_valid_i <= 1'b1;
		evt_i <= {SYN_XLATE_TGT_ABSENT, 32'h0000_0042};
		@(posedge clk_i);
		ce_i <= 1'b1;
		#1;
		`CHK({irq_drop_o, stall_o}, 2'b00)
		@(posedge clk_i);
		evt_valid_i <= 1'b0;
		#1;
		`CHK(irq_drop_o, 1'b1)
		@(posedge clk_i);
		#1;
		`CHK(irq_drop_o, 1'b0)
		rd_chk(TCES_ADDR_SYNDROME, {8'h07, SYN_XLATE_TGT_ABSENT});
		rd_chk(TCES_ADDR_EXTRA, 32'h0000_0042);
		@(posedge clk_i);
		#1;
		`CHK(rdata_o, 32'h0)
		wr(TCES_ADDR_STATUS, 32'h2c00_0000);
		$display("test clock enable hold done");
	endtask

	// ********************************************************
	// run control
	// ********************************************************
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// main sequence after a four-cycle reset
	initial begin
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_table();
		t_overflow();
		t_mask();
		t_hold();
		report_and_stop();
	end

	// watchdog, well beyond the roughly 700 cycles the tests need
	initial begin
		repeat (8000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end
endmodule
